// >>> src/imc_map.svh
`ifndef IMC_MAP_SVH
`define IMC_MAP_SVH
// ----------------------------------------------------------------------
// mode and interrupt state word
// ----------------------------------------------------------------------
`define IMC_ST_IE        0
`define IMC_ST_EXL       1
`define IMC_ST_ERL       2
`define IMC_ST_RSV3      3
`define IMC_ST_UM        4
`define IMC_ST_SWM_LO    8
`define IMC_ST_SWM_HI    9
`define IMC_ST_HWM_LO    10
`define IMC_ST_HWM_HI    15
`define IMC_ST_IPL_LO    10
`define IMC_ST_IPL_HI    16
`define IMC_ST_IPL_TOP   18
`define IMC_ST_RSV_LO    5
`define IMC_ST_RSV_HI    7
// bit 16 is the seventh level bit, so it stays writable
`define IMC_ST_WMASK     32'h0005ff17
`define IMC_ST_RESET     32'h00000004
// ----------------------------------------------------------------------
// routing control word
// ----------------------------------------------------------------------
`define IMC_IC_TI_LO     29
`define IMC_IC_TI_HI     31
`define IMC_IC_PC_LO     26
`define IMC_IC_PC_HI     28
`define IMC_IC_FD_LO     23
`define IMC_IC_FD_HI     25
`define IMC_IC_PF        22
`define IMC_IC_ICE       21
// ----------------------------------------------------------------------
// register select codes
// ----------------------------------------------------------------------
`define IMC_SEL_STATE    1'h0
`define IMC_SEL_ROUTE    1'h1
// ----------------------------------------------------------------------
// user-segment window while at error level
// ----------------------------------------------------------------------
`define IMC_USEG_BITS    29
`endif

// >>> src/imc_pkg.sv
package imc_pkg;
  typedef struct packed {
    logic       we;
    logic       sel;
    logic [31:0] wdata;
  } imc_wr_t;

  typedef struct packed {
    logic kernel;
    logic irq_allowed;
    logic use_error_ret;
    logic useg_unmapped;
    logic hold_epc_cause;
  } imc_mode_t;
endpackage : imc_pkg

// >>> src/imc_ctrl.sv
// Operation
// - external mode: signal when requested level exceeds current
// - otherwise level bits 15:10 act as hardware masks
// - bits 9:8 mask software interrupts
// - external mode: software masks stored, no effect
// - bits 7:5 and 3 read zero
// - bit 4 user mode; flags force kernel
// - error flag set on reset-class exceptions
// - error flag disables interrupts, selects error return
// - error flag: low user segment unmapped, uncached (code drives only mode.useg_unmapped; no cache output)
// - exception flag set on other exceptions
// - bit 0 is master interrupt enable
// - accept only enable=1, flags clear, not debug
// - routing fields read-only when no vectoring
// - timer route in bits 31:29, external value
// - perf and debug routes read-only, static input
`timescale 1ns/1ps
`default_nettype none
`include "imc_map.svh"
module imc_ctrl
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rstn,
  // register access
  input  wire imc_pkg::imc_wr_t wr,
  input  wire logic        rd_sel,
  output logic [31:0]      rdata,
  // configuration straps
  input  wire logic        ext_controller_present,
  input  wire logic        vectored_irq_present,
  input  wire logic [2:0]  timer_irq_route,
  input  wire logic [2:0]  perf_route_static_input,
  input  wire logic [2:0]  debug_channel_irq_route,
  // exception events
  input  wire logic        exc_error_class,
  input  wire logic        exc_other,
  input  wire logic        debug_mode_flag,
  // interrupt sources
  input  wire logic [1:0]  soft_irq_req,
  input  wire logic [5:0]  hw_irq_req,
  input  wire logic [7:0]  requested_level,
  // results
  output logic             irq_pending,
  output imc_pkg::imc_mode_t mode,
  output logic [2:0]       useg_window_bits
);
  // ----------------------------------------------------------------------
  // state word
  // ----------------------------------------------------------------------
  logic [31:0] st;
  logic [31:0] next_st;
  logic        pf;
  logic        next_pf;
  logic        irq_chaining_enable;
  logic        next_ice;
  logic        vec_impl;
  logic [7:0]  level;

  assign vec_impl = ext_controller_present | vectored_irq_present;

  always_comb
  begin
    next_st  = st;
    next_pf  = pf;
    next_ice = irq_chaining_enable;
    if (wr.we && wr.sel == `IMC_SEL_STATE)
      // reserved bits stay zero through the mask
      next_st = wr.wdata & `IMC_ST_WMASK;
    if (wr.we && wr.sel == `IMC_SEL_ROUTE && vec_impl)
    begin
      next_pf  = wr.wdata[`IMC_IC_PF];
      next_ice = wr.wdata[`IMC_IC_ICE];
    end
    // hardware events win over a software write in the same cycle
    if (exc_error_class)
      next_st[`IMC_ST_ERL] = 1'h1;
    if (exc_other)
      next_st[`IMC_ST_EXL] = 1'h1;
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      // undefined fields come up as zero; error flag must be one
      st  <= `IMC_ST_RESET;
      pf  <= 1'h0;
      irq_chaining_enable <= 1'h0;
    end
    else
    begin
      st  <= next_st;
      pf  <= next_pf;
      irq_chaining_enable <= next_ice;
    end
  end

  // ----------------------------------------------------------------------
  // mode and enable decode
  // ----------------------------------------------------------------------
  logic        flags;
  logic        allow;
  logic        sw_hit;
  logic        hw_hit;
  logic        eic_hit;
  logic [31:0] next_rdata;

  assign flags = st[`IMC_ST_ERL] | st[`IMC_ST_EXL];
  assign allow = st[`IMC_ST_IE] & ~flags & ~debug_mode_flag;
  // level spans bit 18 and bits 16:10; software masks stay out of it
  assign level = {st[`IMC_ST_IPL_TOP],
                  st[`IMC_ST_IPL_HI:`IMC_ST_IPL_LO]};
  assign sw_hit = |(soft_irq_req & st[`IMC_ST_SWM_HI:`IMC_ST_SWM_LO]);
  assign hw_hit = |(hw_irq_req & st[`IMC_ST_HWM_HI:`IMC_ST_HWM_LO]);
  assign eic_hit = requested_level > level;

  always_comb
  begin
    // software masks are kept but ignored in external mode
    if (ext_controller_present)
      irq_pending = allow & eic_hit;
    else
      irq_pending = allow & (sw_hit | hw_hit);
    mode.kernel         = ~st[`IMC_ST_UM] | flags;
    mode.irq_allowed    = allow;
    mode.use_error_ret  = st[`IMC_ST_ERL];
    mode.useg_unmapped  = st[`IMC_ST_ERL];
    mode.hold_epc_cause = st[`IMC_ST_EXL];
  end

  assign useg_window_bits = 3'(32 - `IMC_USEG_BITS);

  // ----------------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------------
  always_comb
  begin
    next_rdata = 32'h0;
    if (rd_sel == `IMC_SEL_STATE)
      next_rdata = st;
    else
    begin
      next_rdata[`IMC_IC_TI_HI:`IMC_IC_TI_LO] = timer_irq_route;
      next_rdata[`IMC_IC_PC_HI:`IMC_IC_PC_LO] = perf_route_static_input;
      next_rdata[`IMC_IC_FD_HI:`IMC_IC_FD_LO] = debug_channel_irq_route;
      next_rdata[`IMC_IC_PF]  = pf & vec_impl;
      next_rdata[`IMC_IC_ICE] = irq_chaining_enable & vec_impl;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rstn)
      rdata <= 32'h0;
    else
      rdata <= next_rdata;
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_err_reset_one: assert property (@(posedge clk)
    $rose(rstn) |-> st[`IMC_ST_ERL])
    else $error("error flag not one after reset");
  a_err_event_set: assert property (@(posedge clk) disable iff (!rstn)
    exc_error_class |=> st[`IMC_ST_ERL])
    else $error("error flag not set by event");
  a_exl_event_set: assert property (@(posedge clk) disable iff (!rstn)
    exc_other |=> st[`IMC_ST_EXL])
    else $error("exception flag not set by event");
  a_irq_gate_flags: assert property (@(posedge clk) disable iff (!rstn)
    (flags || !st[`IMC_ST_IE] || debug_mode_flag) |-> !irq_pending)
    else $error("interrupt while disabled");
  a_kernel_forced: assert property (@(posedge clk) disable iff (!rstn)
    flags |-> mode.kernel)
    else $error("user mode with flag set");
  a_rsv_read_zero: assert property (@(posedge clk) disable iff (!rstn)
    ($past(rstn) && $past(rd_sel == `IMC_SEL_STATE)) |->
      (rdata[`IMC_ST_RSV_HI:`IMC_ST_RSV_LO] == 3'h0 &&
       rdata[`IMC_ST_RSV3] == 1'h0))
    else $error("reserved bits not zero");
  a_eic_level: assert property (@(posedge clk) disable iff (!rstn)
    (ext_controller_present && allow && requested_level <= level)
      |-> !irq_pending)
    else $error("interrupt at or below current level");
  a_route_read: assert property (@(posedge clk) disable iff (!rstn)
    ($past(rstn) && $past(rd_sel == `IMC_SEL_ROUTE)) |->
      rdata[`IMC_IC_TI_HI:`IMC_IC_TI_LO] == $past(timer_irq_route))
    else $error("timer route readback wrong");
  a_swm_kept: assert property (@(posedge clk) disable iff (!rstn)
    (wr.we && wr.sel == `IMC_SEL_STATE) |=>
      st[`IMC_ST_SWM_HI:`IMC_ST_SWM_LO] ==
        $past(wr.wdata[`IMC_ST_SWM_HI:`IMC_ST_SWM_LO]))
    else $error("software mask not stored");
  a_pf_reset_off: assert property (@(posedge clk)
    $rose(rstn) |-> (!pf && !irq_chaining_enable))
    else $error("prefetch or chaining not off after reset");
  a_hw_mask_mode: assert property (@(posedge clk) disable iff (!rstn)
    (!ext_controller_present && allow && !sw_hit && !hw_hit) |-> !irq_pending)
    else $error("unmasked hardware interrupt");

  // ----------------------------------------------------------------------
  // checks: interrupt decision
  // ----------------------------------------------------------------------
  // positive checks too, so a stuck-low pending line cannot hide
  a_eic_fire: assert property (@(posedge clk) disable iff (!rstn)
    (ext_controller_present && allow && requested_level > level)
      |-> irq_pending)
    else $error("level above current not signalled");
  a_hw_line_fire: assert property (@(posedge clk) disable iff (!rstn)
    (!ext_controller_present && allow &&
     |(hw_irq_req & st[`IMC_ST_HWM_HI:`IMC_ST_HWM_LO])) |-> irq_pending)
    else $error("enabled hardware line not signalled");
  a_sw_line_fire: assert property (@(posedge clk) disable iff (!rstn)
    (!ext_controller_present && allow &&
     |(soft_irq_req & st[`IMC_ST_SWM_HI:`IMC_ST_SWM_LO])) |-> irq_pending)
    else $error("enabled software request not signalled");
  a_sw_mask_off: assert property (@(posedge clk) disable iff (!rstn)
    (!ext_controller_present && st[`IMC_ST_SWM_HI:`IMC_ST_SWM_LO] == 2'h0 &&
     (hw_irq_req & st[`IMC_ST_HWM_HI:`IMC_ST_HWM_LO]) == 6'h0)
      |-> !irq_pending)
    else $error("masked software request signalled");
  a_eic_sw_ignored: assert property (@(posedge clk) disable iff (!rstn)
    (ext_controller_present && |soft_irq_req && requested_level <= level)
      |-> !irq_pending)
    else $error("software mask leaked into external mode");

  // ----------------------------------------------------------------------
  // checks: mode outputs
  // ----------------------------------------------------------------------
  a_allow_open: assert property (@(posedge clk) disable iff (!rstn)
    (st[`IMC_ST_IE] && !st[`IMC_ST_ERL] && !st[`IMC_ST_EXL] &&
     !debug_mode_flag) |-> mode.irq_allowed)
    else $error("interrupts blocked with gates open");
  a_allow_debug: assert property (@(posedge clk) disable iff (!rstn)
    (debug_mode_flag || !st[`IMC_ST_IE]) |-> !mode.irq_allowed)
    else $error("interrupts allowed in debug or disabled");
  a_user_mode: assert property (@(posedge clk) disable iff (!rstn)
    (st[`IMC_ST_UM] && !flags) |-> !mode.kernel)
    else $error("kernel mode with user bit and no flag");
  a_err_return: assert property (@(posedge clk) disable iff (!rstn)
    st[`IMC_ST_ERL] |-> (mode.use_error_ret && !mode.irq_allowed))
    else $error("error level without error return");
  a_useg_window: assert property (@(posedge clk) disable iff (!rstn)
    st[`IMC_ST_ERL] |-> mode.useg_unmapped)
    else $error("user segment mapped at error level");
  a_exl_hold: assert property (@(posedge clk) disable iff (!rstn)
    st[`IMC_ST_EXL] |-> (mode.hold_epc_cause && !mode.irq_allowed))
    else $error("exception level does not hold saved state");

  // ----------------------------------------------------------------------
  // checks: register access
  // ----------------------------------------------------------------------
  a_rsv_never_set: assert property (@(posedge clk) disable iff (!rstn)
    (st & ~`IMC_ST_WMASK) == 32'h0)
    else $error("unwritable status bit holds a one");
  a_rd_state: assert property (@(posedge clk) disable iff (!rstn)
    ($past(rstn) && $past(rd_sel == `IMC_SEL_STATE)) |-> rdata == $past(st))
    else $error("state word readback wrong");
  a_ie_write: assert property (@(posedge clk) disable iff (!rstn)
    (wr.we && wr.sel == `IMC_SEL_STATE) |=>
      st[`IMC_ST_IE] == $past(wr.wdata[`IMC_ST_IE]))
    else $error("master enable not stored");
  a_um_write: assert property (@(posedge clk) disable iff (!rstn)
    (wr.we && wr.sel == `IMC_SEL_STATE) |=>
      st[`IMC_ST_UM] == $past(wr.wdata[`IMC_ST_UM]))
    else $error("base mode bit not stored");
  // an event in the same cycle wins, so it is left out here
  a_err_sw_write: assert property (@(posedge clk) disable iff (!rstn)
    (wr.we && wr.sel == `IMC_SEL_STATE && !exc_error_class) |=>
      st[`IMC_ST_ERL] == $past(wr.wdata[`IMC_ST_ERL]))
    else $error("error flag write lost");
  a_exl_sw_write: assert property (@(posedge clk) disable iff (!rstn)
    (wr.we && wr.sel == `IMC_SEL_STATE && !exc_other) |=>
      st[`IMC_ST_EXL] == $past(wr.wdata[`IMC_ST_EXL]))
    else $error("exception flag write lost");
  a_ipl_write: assert property (@(posedge clk) disable iff (!rstn)
    (wr.we && wr.sel == `IMC_SEL_STATE) |=>
      level == {$past(wr.wdata[`IMC_ST_IPL_TOP]),
                $past(wr.wdata[`IMC_ST_IPL_HI:`IMC_ST_IPL_LO])})
    else $error("priority level not stored");
  a_pf_write: assert property (@(posedge clk) disable iff (!rstn)
    (vec_impl && wr.we && wr.sel == `IMC_SEL_ROUTE) |=>
      (pf == $past(wr.wdata[`IMC_IC_PF]) &&
       irq_chaining_enable == $past(wr.wdata[`IMC_IC_ICE])))
    else $error("prefetch or chaining write lost");
  // no vectoring: the two enables must never leave zero
  a_pf_novec: assert property (@(posedge clk) disable iff (!rstn)
    !vec_impl |-> (!pf && !irq_chaining_enable))
    else $error("prefetch or chaining set without vectoring");
  a_route_static: assert property (@(posedge clk) disable iff (!rstn)
    ($past(rstn) && $past(rd_sel == `IMC_SEL_ROUTE)) |->
      (rdata[`IMC_IC_PC_HI:`IMC_IC_PC_LO] == $past(perf_route_static_input)
       && rdata[`IMC_IC_FD_HI:`IMC_IC_FD_LO] ==
          $past(debug_channel_irq_route)))
    else $error("performance or debug route readback wrong");
endmodule : imc_ctrl
`default_nettype wire

// >>> testbench/imc_far_model.sv
`timescale 1ns/1ps
`default_nettype none
module imc_far_model
#(
  parameter logic [2:0] perf_line = 3'h5
)
(
  // clock
  input  wire logic       clk,
  // wanted requests
  input  wire logic [5:0] want_hw,
  input  wire logic [7:0] want_level,
  // toward the block
  output logic      [5:0] hw_irq_req,
  output logic      [7:0] requested_level,
  output logic      [2:0] perf_route_static_input
);
  // strapped, never moves while running
  assign perf_route_static_input = perf_line;
  // sources answer one edge late, as real glue logic does
  always_ff @(posedge clk)
  begin
    hw_irq_req      <= want_hw;
    requested_level <= want_level;
  end
endmodule : imc_far_model
`default_nettype wire

// >>> testbench/imc_ctrl_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "imc_map.svh"
module imc_ctrl_test;
  logic clk, rstn, rd_sel, ext, vec, exc_err, exc_oth, dm, irq;
  imc_pkg::imc_wr_t   wr;
  imc_pkg::imc_mode_t mode;
  logic [31:0] rdata, st, r;
  logic [1:0]  sreq, rc;
  logic [5:0]  whw, hw;
  logic [7:0]  wlvl, lvl;
  logic [2:0]  perf, ubits;
  int          errors, num_checks, seed, i, ph;
  imc_ctrl imc_ctrl_i (.clk(clk), .rstn(rstn), .wr(wr), .rd_sel(rd_sel),
    .rdata(rdata), .ext_controller_present(ext), .vectored_irq_present(vec),
    .timer_irq_route(3'h2), .perf_route_static_input(perf),
    .debug_channel_irq_route(3'h7), .exc_error_class(exc_err),
    .exc_other(exc_oth), .debug_mode_flag(dm), .soft_irq_req(sreq),
    .hw_irq_req(hw), .requested_level(lvl), .irq_pending(irq),
    .mode(mode), .useg_window_bits(ubits));
  imc_far_model imc_far_model_i (.clk(clk), .want_hw(whw),
    .want_level(wlvl), .hw_irq_req(hw), .requested_level(lvl),
    .perf_route_static_input(perf));
  // ----------------------------------------------------------------
  // expectation
  // ----------------------------------------------------------------
  function automatic logic exp_irq();
    logic ok;
    ok = st[0] & !st[1] & !st[2] & !dm;
    if (ext)
      return ok & (lvl > {st[18], st[16], st[15:10]});
    return ok & (|(sreq & st[9:8]) | |(hw & st[15:10]));
  endfunction : exp_irq
  function automatic imc_pkg::imc_mode_t exp_mode();
    return '{!st[4] | st[1] | st[2], st[0] & !st[1] & !st[2] & !dm,
             st[2], st[2], st[1]};
  endfunction : exp_mode
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task final_report();
    $display("errors %0d checks %0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  // ----------------------------------------------------------------
  // drivers
  // ----------------------------------------------------------------
  task tick();
    @(posedge clk);
    #1;
  endtask : tick
  task wrt(input logic s, input logic [31:0] d);
    tick();
    wr = '{1'b1, s, d};
    tick();
    wr.we = 1'b0;
    if (!s)
      st = d & `IMC_ST_WMASK;
    else if (vec | ext)
      rc = d[22:21];
  endtask : wrt
  task rdchk(input logic s, input logic [31:0] e);
    rd_sel = s;
    tick();
    chk(rdata, e);
  endtask : rdchk
  task cmp();
    chk(irq, exp_irq());
    chk(mode, exp_mode());
    chk(ubits, 3'h3);
  endtask : cmp
  task pulse(input logic err);
    tick();
    exc_err = err;
    exc_oth = !err;
    tick();
    exc_err = 1'b0;
    exc_oth = 1'b0;
    st[err ? 2 : 1] = 1'b1;
  endtask : pulse
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  initial
  begin
    #400000;
    errors++;
    final_report();
  end
  initial
  begin
    {rstn, rd_sel, ext, vec, exc_err, exc_oth, dm, sreq} = '0;
    wr = '0;
    whw = '0;
    wlvl = '0;
    seed = 38844;
    for (ph = 0; ph < 3; ph++)
    begin
      tick();
      rstn = 1'b0;
      ext = (ph == 2);
      vec = (ph == 1);
      dm = 1'b0;
      sreq = 2'h0;
      repeat (16) tick();
      rstn = 1'b1;
      st = 32'h4;
      rc = 2'h0;
      cmp();
      rdchk(1'b0, st);
      rdchk(1'b1, {3'h2, perf, 3'h7, rc, 21'h0});
      wrt(1'b1, 32'hffffffff);
      rdchk(1'b1, {3'h2, perf, 3'h7, rc, 21'h0});
      wrt(1'b0, 32'hffffffff);
      rdchk(1'b0, `IMC_ST_WMASK);
      wrt(1'b0, 32'h0000fd11);
      pulse(1'b0);
      cmp();
      pulse(1'b1);
      cmp();
      tick();
      wr = '{1'b1, 1'b0, 32'h00000011};
      exc_oth = 1'b1;
      tick();
      wr.we = 1'b0;
      exc_oth = 1'b0;
      st = 32'h13;
      rdchk(1'b0, st);
      wrt(1'b0, 32'h0000ff01);
      sreq = ext ? 2'h3 : 2'h0;
      for (i = 0; i < 4; i++)
      begin
        wlvl = 8'h3e + i[7:0];
        whw = 6'h1 << i;
        tick();
        cmp();
      end
      for (i = 0; i < 120; i++)
      begin
        r = $random(seed);
        wrt(1'b0, r & ~32'h6);
        r = $random(seed);
        whw = r[5:0];
        wlvl = r[15:8];
        sreq = r[17:16];
        dm = (r[21:19] == 3'h0);
        tick();
        cmp();
        if (i % 8 == 0)
          rdchk(1'b0, st);
      end
    end
    final_report();
  end
endmodule : imc_ctrl_test
`default_nettype wire
